// *** shared/tocu_params.svh ***
// Offsets, field positions, reset values and timing counts of the compare unit.
// Assumes byte addresses on a 32-bit Avalon-MM bus, one register per word.
`ifndef TOCU_PARAMS_SVH
`define TOCU_PARAMS_SVH

// Register byte addresses
`define TOCU_OFS_CTRL 5'h00
`define TOCU_OFS_COUNT 5'h04
`define TOCU_OFS_CMP0 5'h08
`define TOCU_OFS_CMP1 5'h0C
`define TOCU_OFS_FORCE 5'h10
`define TOCU_OFS_FLAGS 5'h14
`define TOCU_OFS_MASK 5'h18
`define TOCU_OFS_OUT 5'h1C

// Control field positions
`define TOCU_CTRL_WGM_LSB 0
`define TOCU_CTRL_COM_LSB 3

// Waveform mode codes
`define TOCU_WGM_NORMAL 3'h0
`define TOCU_WGM_CLEAR 3'h2

// Reset values
`define TOCU_RST_CTRL 32'h0000_0000
`define TOCU_RST_MASK 8'h00

// Wait cycles before the slave answers
`define TOCU_WAIT_CYCLES 1

`endif

// *** shared/tocu_pkg.sv ***
// Types shared by the compare unit files.
// Assumes the counter unit drives a tocu_cnt_t on the system clock.
package tocu_pkg;

  // Counter unit view, all on clk_sys
  typedef struct packed {
    logic [7:0] value;
    logic tick;
    logic atTop;
    logic atBottom;
    logic countDown;
  } tocu_cnt_t;

  // Per-channel mode view
  typedef struct packed {
    logic pwm;
    logic fast;
    logic [1:0] outMode;
  } tocu_chcfg_t;

endpackage : tocu_pkg

// *** rtl/tocu_channel.sv ***
// One output compare channel: buffer, active compare value, output state.
// Assumes counter ticks and CPU writes arrive on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tocu_channel
  import tocu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire tocu_pkg::tocu_cnt_t cnt,
  input wire tocu_pkg::tocu_chcfg_t cfg,
  input wire logic cpuWrite,
  input wire logic [7:0] cpuData,
  input wire logic forceStrobe,
  input wire logic blocked,
  input wire logic xferPoint,
  output logic [7:0] cpuView,
  output logic realMatch,
  output var logic ocState_q
);
  logic [7:0] buffer_q;
  logic [7:0] active_q;
  logic forceHit;

  // Level to take on a match, given mode and output mode bits
  function automatic logic onMatch(input tocu_chcfg_t c, input logic cur, input logic down);
    logic lvl;
    lvl = cur;
    if (!c.pwm)
    begin
      case (c.outMode)
        2'h1: lvl = ~cur;
        2'h2: lvl = 1'b0;
        2'h3: lvl = 1'b1;
        default: lvl = cur;
      endcase
    end
    else if (c.outMode[1])
    begin
      lvl = c.outMode[0] ^ (!c.fast && down);
    end
    return lvl;
  endfunction : onMatch

  // Buffer only written while a PWM mode is selected
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      buffer_q <= 8'h00;
    else if (cpuWrite && cfg.pwm)
      buffer_q <= cpuData; // R1 R4
  end

  // Direct write in non-PWM modes, synchronized transfer otherwise
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      active_q <= 8'h00;
    else if (cpuWrite && !cfg.pwm)
      active_q <= cpuData; // R2 R4
    else if (cfg.pwm && cnt.tick && xferPoint)
      active_q <= buffer_q; // R3
  end

  assign cpuView = cfg.pwm ? buffer_q : active_q; // R4
  // Comparator never looks at the buffer
  assign realMatch = cnt.tick && (cnt.value == active_q) && !blocked; // R19 R8
  assign forceHit = forceStrobe && !cfg.pwm; // R5

  // Output state; mode changes leave it alone
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ocState_q <= 1'b0; // R15
    else if (realMatch || forceHit)
      ocState_q <= onMatch(cfg, ocState_q, cnt.countDown); // R7 R13
    else if (cfg.pwm && cfg.fast && cfg.outMode[1] && cnt.tick && cnt.atBottom)
      ocState_q <= ~cfg.outMode[0]; // R11
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_direct_write: assert property (cpuWrite && !cfg.pwm |=> active_q == $past(cpuData)) // R2
    else $error("direct compare write not applied");
  a_buffer_hold: assert property (cfg.pwm && !(cnt.tick && xferPoint) |=> $stable(active_q)) // R3
    else $error("active compare changed outside transfer point");
  a_force_toggle: assert property (forceHit && !realMatch && cfg.outMode == 2'h1
    |=> ocState_q != $past(ocState_q)) // R7
    else $error("forced toggle did not change output state");
endmodule : tocu_channel
`default_nettype wire

// *** rtl/tocu_top.sv ***
// Output compare unit of an 8-bit timer with an Avalon-MM register slave.
// Assumes the counter unit, port logic and bus master all run on clk_sys.
//
// Notes on behaviour
// R1: Compare values are double-buffered in every PWM mode.
// R2: Normal and clear-on-match modes write compare values straight to the comparator.
// R3: Buffered values move to the active register only at top or bottom.
// R4: CPU reaches the buffer when buffering, else the active register.
// R5: Force strobe in non-PWM modes forces the channel's match output.
// R6: A forced match sets no flag and never clears the counter.
// R7: A forced match updates output state exactly like a real match.
// R8: A counter write blocks all matches in the following timer cycle.
// R9: Software should not load zero while the counter counts down.
// R10: Software should set output state before making the pin an output.
// R11: Output state is kept when the waveform mode changes.
// R12: Output mode bits are unbuffered and act at once.
// R13: Output mode bits choose the state applied at the next match.
// R14: Output mode bits choose compare output or port logic for the pin.
// R15: Reset clears every channel's internal output state to zero.
// R16: A counter match sets the channel's match flag at the timer tick.
// R17: Match flag clears on interrupt acknowledge or a written one.
// R18: Any set output mode bit makes the compare output own the pin.
// R19: The comparator uses the active register, never the buffer.
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tocu_params.svh"
module tocu_top
  import tocu_pkg::*;
#(
  parameter int NCHAN = 2
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire tocu_pkg::tocu_cnt_t counterIn,
  input wire logic [NCHAN-1:0] intAck,
  input wire logic [NCHAN-1:0] portData,
  output logic counterLoad,
  output logic [7:0] counterLoadValue,
  output logic counterClear,
  output logic [NCHAN-1:0] pinLevel,
  output logic [NCHAN-1:0] pinOverride,
  output logic irq
);
  logic [31:0] readdata_q;
  logic waitReq_q;
  logic [31:0] ctrl_q;
  logic [7:0] mask_q;
  logic [NCHAN-1:0] flags_q;
  logic blocked_q;
  logic counterLoad_q;
  logic [7:0] counterLoadValue_q;
  logic counterClear_q;
  logic [NCHAN-1:0] pinLevel_q;
  logic [NCHAN-1:0] pinOverride_q;
  logic irq_q;
  logic accept;
  logic wrAccept;
  logic [2:0] waveMode;
  logic pwmMode;
  logic fastMode;
  logic xferPoint;
  logic [NCHAN-1:0] realMatch;
  logic [NCHAN-1:0] ocState;
  logic [NCHAN-1:0] forceStrobe;
  logic [7:0] cpuView [NCHAN];

  // Address decode, shared by the read mux and all write paths
  function automatic logic regHit(input logic [4:0] addr, input logic [4:0] ofs);
    return addr == ofs;
  endfunction : regHit

  // Output mode bits of one channel straight from the control word
  function automatic logic [1:0] outModeOf(input logic [31:0] ctrl, input int idx);
    return ctrl[`TOCU_CTRL_COM_LSB + 2 * idx +: 2];
  endfunction : outModeOf

  // The map holds two compare words; a third would land on the force strobe
  if (NCHAN < 1 || NCHAN > 2)
  begin : g_bad_nchan
    $error("NCHAN must be 1 or 2");
  end

  // Only byte lane 0 carries write data
  assign accept = (read || write) && !waitReq_q;
  assign wrAccept = accept && write && byteenable[0];

  // One wait cycle per access, then the answer
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      waitReq_q <= 1'b1;
    else if ((read || write) && waitReq_q)
      waitReq_q <= 1'b0;
    else
      waitReq_q <= 1'b1;
  end

  // Read data captured while waitrequest is still high
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      readdata_q <= 32'h0000_0000;
    else if (read && waitReq_q)
    begin
      readdata_q <= 32'h0000_0000;
      if (regHit(address, `TOCU_OFS_CTRL))
        readdata_q <= ctrl_q;
      else if (regHit(address, `TOCU_OFS_COUNT))
        readdata_q <= {24'h00_0000, counterIn.value};
      else if (regHit(address, `TOCU_OFS_CMP0))
        readdata_q <= {24'h00_0000, cpuView[0]}; // R4
      else if (regHit(address, `TOCU_OFS_CMP1) && NCHAN > 1)
        readdata_q <= {24'h00_0000, cpuView[NCHAN > 1 ? 1 : 0]}; // R4
      else if (regHit(address, `TOCU_OFS_FLAGS))
        readdata_q[NCHAN-1:0] <= flags_q;
      else if (regHit(address, `TOCU_OFS_MASK))
        readdata_q[7:0] <= mask_q;
      else if (regHit(address, `TOCU_OFS_OUT))
        readdata_q[15:0] <= {8'(pinOverride_q), 8'(ocState)};
    end
  end

  // Control word; mode bits act at once, never buffered
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ctrl_q <= `TOCU_RST_CTRL;
    else if (wrAccept && regHit(address, `TOCU_OFS_CTRL))
      ctrl_q <= {16'h0000, 8'h00, writedata[7:0]}; // R12
  end

  // Interrupt mask
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      mask_q <= `TOCU_RST_MASK;
    else if (wrAccept && regHit(address, `TOCU_OFS_MASK))
      mask_q <= writedata[7:0];
  end

  assign waveMode = ctrl_q[`TOCU_CTRL_WGM_LSB +: 3];
  // Odd mode codes are the PWM modes
  assign pwmMode = waveMode[0]; // R1 R2
  assign fastMode = waveMode[0] && waveMode[1];
  // Fast PWM reloads at bottom, phase correct at top
  assign xferPoint = fastMode ? counterIn.atBottom : counterIn.atTop; // R3

  // Counter load request handed to the counter unit
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      counterLoad_q <= 1'b0;
      counterLoadValue_q <= 8'h00;
    end
    else
    begin
      counterLoad_q <= wrAccept && regHit(address, `TOCU_OFS_COUNT);
      if (wrAccept && regHit(address, `TOCU_OFS_COUNT))
        counterLoadValue_q <= writedata[7:0];
    end
  end

  // Block stays until a tick passes, so a stopped timer keeps it armed
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      blocked_q <= 1'b0;
    else if (wrAccept && regHit(address, `TOCU_OFS_COUNT))
      blocked_q <= 1'b1; // R8
    else if (counterIn.tick)
      blocked_q <= 1'b0; // R8
  end

  // Channels share the mode view; each has its own output mode bits
  for (genvar i = 0; i < NCHAN; i++)
  begin : g_chan
    tocu_chcfg_t cfg;
    logic [4:0] cmpOfs;
    assign cmpOfs = 5'(`TOCU_OFS_CMP0 + 4 * i);
    assign cfg = '{pwm: pwmMode, fast: fastMode, outMode: outModeOf(ctrl_q, i)}; // R12
    assign forceStrobe[i] = wrAccept && regHit(address, `TOCU_OFS_FORCE) && writedata[i]; // R5

    tocu_channel u_chan (
      .clk_sys(clk_sys),
      .reset(reset),
      .cnt(counterIn),
      .cfg(cfg),
      .cpuWrite(wrAccept && regHit(address, cmpOfs)),
      .cpuData(writedata[7:0]),
      .forceStrobe(forceStrobe[i]),
      .blocked(blocked_q),
      .xferPoint(xferPoint),
      .cpuView(cpuView[i]),
      .realMatch(realMatch[i]),
      .ocState_q(ocState[i])
    );

    // Set wins over both clears
    always_ff @(posedge clk_sys)
    begin
      if (reset)
        flags_q[i] <= 1'b0;
      else if (realMatch[i])
        flags_q[i] <= 1'b1; // R16 R6
      else if (intAck[i] || (wrAccept && regHit(address, `TOCU_OFS_FLAGS) && writedata[i]))
        flags_q[i] <= 1'b0; // R17
    end

    // Pin source chosen by the output mode bits
    always_ff @(posedge clk_sys)
    begin
      if (reset)
      begin
        pinOverride_q[i] <= 1'b0;
        pinLevel_q[i] <= 1'b0;
      end
      else
      begin
        pinOverride_q[i] <= |cfg.outMode; // R14 R18
        pinLevel_q[i] <= (|cfg.outMode) ? ocState[i] : portData[i]; // R14 R18
      end
    end
  end

  // Only channel 0 real matches may clear the counter
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      counterClear_q <= 1'b0;
    else
      counterClear_q <= realMatch[0] && waveMode == `TOCU_WGM_CLEAR; // R6
  end

  // Level interrupt, one cycle behind the flags
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      irq_q <= 1'b0;
    else
      irq_q <= |(flags_q & mask_q[NCHAN-1:0]);
  end

  assign readdata = readdata_q;
  assign waitrequest = waitReq_q;
  assign counterLoad = counterLoad_q;
  assign counterLoadValue = counterLoadValue_q;
  assign counterClear = counterClear_q;
  assign pinLevel = pinLevel_q;
  assign pinOverride = pinOverride_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("slave did not answer after one wait cycle");
  a_block_match: assert property (blocked_q && counterIn.tick |-> realMatch == '0) // R8
    else $error("match passed while blocked after counter write");
  a_block_arm: assert property (wrAccept && regHit(address, `TOCU_OFS_COUNT)
    |=> blocked_q && counterLoad) // R8
    else $error("counter write did not arm the block");
  a_force_noflag: assert property (forceStrobe[0] && !realMatch[0] && !flags_q[0]
    |=> !flags_q[0] && !counterClear) // R6
    else $error("forced match set a flag or cleared the counter");
  a_flag_set: assert property (realMatch[0] |=> flags_q[0] ##1 (irq || !$past(mask_q[0]))) // R16
    else $error("match flag or interrupt level wrong after match");
  a_flag_clear: assert property (intAck[0] && !realMatch[0] |=> !flags_q[0]) // R17
    else $error("acknowledge did not clear match flag");
  a_pin_source: assert property (ctrl_q[`TOCU_CTRL_COM_LSB +: 2] == 2'h0 && $stable(ctrl_q)
    |=> !pinOverride[0] && pinLevel[0] == $past(portData[0])) // R14
    else $error("pin not driven by port logic with output mode off");
  a_reset_state: assert property ($fell(reset) |-> ocState == '0 && flags_q == '0) // R15
    else $error("output state not zero after reset");

  // Checks on the bus handshake, pins, flags and counter requests
  a_wait_idle: assert property (!read && !write |=> waitrequest)
    else $error("waitrequest low without a request");
  a_ctrl_write: assert property (wrAccept && regHit(address, `TOCU_OFS_CTRL) // R12
    |=> ctrl_q[7:0] == $past(writedata[7:0]))
    else $error("control write not applied at once");
  a_load_value: assert property (wrAccept && regHit(address, `TOCU_OFS_COUNT)
    |=> counterLoadValue == $past(writedata[7:0]))
    else $error("counter load value not taken from write");
  a_override_src: assert property (|ctrl_q[`TOCU_CTRL_COM_LSB +: 2] // R18 R14
    |=> pinOverride[0] && pinLevel[0] == $past(ocState[0]))
    else $error("pin not driven by compare output");
  a_flag_hold: assert property (flags_q[0] && !intAck[0] // R17
    && !(wrAccept && regHit(address, `TOCU_OFS_FLAGS) && writedata[0]) |=> flags_q[0])
    else $error("match flag cleared without a clear");
  a_clear_source: assert property (counterClear // R6
    |-> $past(realMatch[0]) && $past(waveMode) == `TOCU_WGM_CLEAR)
    else $error("counter clear without a real match in clear mode");
  a_irq_level: assert property (|(flags_q & mask_q[NCHAN-1:0]) |=> irq)
    else $error("interrupt low with an unmasked flag set");
endmodule : tocu_top
`default_nettype wire

// *** sim/tocu_top_bench.sv ***
// Self-checking bench for the timer output compare unit, two channels.
// Assumes the bench plays the counter unit, the port logic and the bus master.
`timescale 1ns/1ps
`default_nettype none
`include "tocu_params.svh"
module tocu_top_bench;
  import tocu_pkg::*;
  logic clk_sys;
  logic reset;
  logic [4:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  tocu_cnt_t counterIn;
  logic [1:0] intAck;
  logic [1:0] portData;
  logic counterLoad;
  logic [7:0] counterLoadValue;
  logic counterClear;
  logic [1:0] pinLevel;
  logic [1:0] pinOverride;
  logic irq;
  int error_cnt;
  int n_checks;
  int clrCnt;
  int loadCnt;
  logic [31:0] rd;

  tocu_top #(.NCHAN(2)) i_dut (
    .clk_sys(clk_sys),
    .reset(reset),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .counterIn(counterIn),
    .intAck(intAck),
    .portData(portData),
    .counterLoad(counterLoad),
    .counterLoadValue(counterLoadValue),
    .counterClear(counterClear),
    .pinLevel(pinLevel),
    .pinOverride(pinOverride),
    .irq(irq)
  );

  // 100 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Counts one-cycle pulses so a scenario cannot miss them
  always @(posedge clk_sys)
  begin
    if (counterClear === 1'b1) clrCnt <= clrCnt + 1;
    if (counterLoad === 1'b1) loadCnt <= loadCnt + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One Avalon access; entered just after an edge, leaves one idle cycle
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    // Only the watchdog ends a wait that never gets an answer
    do
      @(posedge clk_sys);
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk

  // One timer clock edge with the given count
  task automatic tick(input logic [7:0] v, input logic bot);
    counterIn <= '{value: v, tick: 1'b1, atTop: 1'b0, atBottom: bot, countDown: 1'b0};
    @(posedge clk_sys);
    counterIn.tick <= 1'b0;
    @(posedge clk_sys);
  endtask : tick

  task automatic t_reset;
    rchk(`TOCU_OFS_CTRL, 32'h0);
    rchk(`TOCU_OFS_OUT, 32'h0);
    rchk(5'h02, 32'h0);
    bus(1'b1, `TOCU_OFS_MASK, 32'h3);
    rchk(`TOCU_OFS_MASK, 32'h3);
    // A write without byte lane 0 must be ignored
    byteenable <= 4'hE;
    bus(1'b1, `TOCU_OFS_MASK, 32'h0);
    byteenable <= 4'hF;
    rchk(`TOCU_OFS_MASK, 32'h3);
  endtask : t_reset

  task automatic t_match;
    bus(1'b1, `TOCU_OFS_CMP0, 32'h05);
    rchk(`TOCU_OFS_CMP0, 32'h05);
    bus(1'b1, `TOCU_OFS_CTRL, 32'h08);
    tick(8'h05, 1'b0);
    rchk(`TOCU_OFS_FLAGS, 32'h1);
    rchk(`TOCU_OFS_OUT, 32'h0101);
    check(32'(irq), 32'h1);
    bus(1'b1, `TOCU_OFS_FLAGS, 32'h1);
    rchk(`TOCU_OFS_FLAGS, 32'h0);
    check(32'(irq), 32'h0);
    tick(8'h05, 1'b0);
    rchk(`TOCU_OFS_OUT, 32'h0100);
    bus(1'b1, `TOCU_OFS_MASK, 32'h0);
    @(posedge clk_sys);
    check(32'(irq), 32'h0);
    bus(1'b1, `TOCU_OFS_MASK, 32'h3);
    @(posedge clk_sys);
    check(32'(irq), 32'h1);
    intAck <= 2'b01;
    @(posedge clk_sys);
    intAck <= 2'b00;
    @(posedge clk_sys);
    rchk(`TOCU_OFS_FLAGS, 32'h0);
  endtask : t_match

  // Clear-on-match mode, ch0 set, ch1 toggle
  task automatic t_force;
    bus(1'b1, `TOCU_OFS_CMP1, 32'h77);
    bus(1'b1, `TOCU_OFS_CTRL, 32'h3A);
    bus(1'b1, `TOCU_OFS_FORCE, 32'h3);
    rchk(`TOCU_OFS_OUT, 32'h0303);
    rchk(`TOCU_OFS_FLAGS, 32'h0);
    check(32'(clrCnt), 32'h0);
    tick(8'h05, 1'b0);
    rchk(`TOCU_OFS_FLAGS, 32'h1);
    check(32'(clrCnt), 32'h1);
    bus(1'b1, `TOCU_OFS_FLAGS, 32'h3);
  endtask : t_force

  // Counter write while stopped, long gap before the next tick
  task automatic t_block;
    bus(1'b1, `TOCU_OFS_COUNT, 32'h05);
    check(32'(counterLoadValue), 32'h05);
    repeat (10) @(posedge clk_sys);
    check(32'(loadCnt), 32'h1);
    tick(8'h05, 1'b0);
    rchk(`TOCU_OFS_FLAGS, 32'h0);
    check(32'(clrCnt), 32'h1);
    tick(8'h05, 1'b0);
    rchk(`TOCU_OFS_FLAGS, 32'h1);
    bus(1'b1, `TOCU_OFS_FLAGS, 32'h3);
  endtask : t_block

  // Fast PWM, no output modes: buffered compare value
  task automatic t_pwm;
    bus(1'b1, `TOCU_OFS_CTRL, 32'h03);
    rchk(`TOCU_OFS_OUT, 32'h0003);
    check(32'(pinOverride), 32'h0);
    check(32'(pinLevel), 32'h3);
    bus(1'b1, `TOCU_OFS_CMP0, 32'h40);
    tick(8'h40, 1'b0);
    rchk(`TOCU_OFS_FLAGS, 32'h0);
    tick(8'h00, 1'b1);
    tick(8'h40, 1'b0);
    rchk(`TOCU_OFS_FLAGS, 32'h1);
    bus(1'b1, `TOCU_OFS_FLAGS, 32'h3);
  endtask : t_pwm

  // Normal mode, ch0 clear: mode bits act at once, writes go direct
  task automatic t_mode;
    bus(1'b1, `TOCU_OFS_CTRL, 32'h10);
    @(posedge clk_sys);
    check(32'(pinOverride), 32'h1);
    tick(8'h40, 1'b0);
    rchk(`TOCU_OFS_OUT, 32'h0102);
    check(32'(pinLevel), 32'h2);
    bus(1'b1, `TOCU_OFS_FLAGS, 32'h3);
    bus(1'b1, `TOCU_OFS_CMP0, 32'h30);
    tick(8'h30, 1'b0);
    rchk(`TOCU_OFS_FLAGS, 32'h1);
  endtask : t_mode

  // One timer clock edge of a phase correct count
  task automatic tick_pc(input logic [7:0] v, input logic top, input logic down);
    counterIn <= '{value: v, tick: 1'b1, atTop: top, atBottom: 1'b0, countDown: down};
    @(posedge clk_sys);
    counterIn.tick <= 1'b0;
    @(posedge clk_sys);
  endtask : tick_pc

  // Phase correct PWM, ch0 clear counting up, set counting down
  task automatic t_phase;
    bus(1'b1, `TOCU_OFS_FLAGS, 32'h3);
    bus(1'b1, `TOCU_OFS_CTRL, 32'h11);
    bus(1'b1, `TOCU_OFS_CMP0, 32'h20);
    rchk(`TOCU_OFS_CMP0, 32'h20);
    tick_pc(8'h20, 1'b0, 1'b0);
    rchk(`TOCU_OFS_FLAGS, 32'h0);
    tick_pc(8'hFF, 1'b1, 1'b0);
    tick_pc(8'h20, 1'b0, 1'b1);
    rchk(`TOCU_OFS_OUT, 32'h0103);
    tick_pc(8'h20, 1'b0, 1'b0);
    rchk(`TOCU_OFS_OUT, 32'h0102);
    rchk(`TOCU_OFS_FLAGS, 32'h1);
  endtask : t_phase

  task automatic conclude;
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // Main sequence
  initial
  begin
    reset = 1'b1;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hF;
    writedata = 32'h0;
    counterIn = '0;
    intAck = 2'b00;
    portData = 2'b11;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_match;
    t_force;
    t_block;
    t_pwm;
    t_mode;
    t_phase;
    conclude;
  end

  // Watchdog; the whole run needs under two hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    conclude;
  end
endmodule : tocu_top_bench
`default_nettype wire
